// ==== src/dsc_cmd_exec.sv ====
// dsc_cmd_exec: executes decoded display, output, aux and setup commands
// assumes cmd_valid is a one-cycle pulse from a parser on clk; aux input words are pre-synchronised samples
`timescale 1ns/1ps
`default_nettype none
module dsc_cmd_exec (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                cmd_valid,
  input  wire dsc_pkg::dsc_cmd_t   cmd,
  input  wire logic signed [15:0]  meas_x,
  input  wire logic signed [15:0]  meas_y,
  input  wire logic signed [15:0]  meas_r,
  input  wire logic signed [15:0]  aux_in1,
  input  wire logic signed [15:0]  aux_in2,
  input  wire logic signed [15:0]  aux_in3,
  input  wire logic signed [15:0]  aux_in4,
  output logic                     reply_valid,
  output dsc_pkg::dsc_reply_t      reply,
  output logic                     cmd_error,
  output dsc_pkg::dsc_setup_t      setup,
  output logic                     reply_gpib,
  output logic                     override_remote,
  output logic                     remote_state,
  output logic                     panel_locked
);

  dsc_pkg::dsc_setup_t  setup_q;
  dsc_pkg::dsc_setup_t  setup_d;
  dsc_pkg::dsc_reply_t  reply_q;
  dsc_pkg::dsc_reply_t  reply_d;
  logic                 reply_valid_q;
  logic                 error_q;
  logic                 gpib_q;
  logic                 ovr_q;
  logic                 remote_q;
  logic                 ok;
  logic                 store_save;
  dsc_pkg::dsc_setup_t  slot_data;
  logic                 slot_used;

  function automatic logic ofs_in_range(input logic signed [15:0] v);
    ofs_in_range = (v <= dsc_pkg::DSC_OFS_LIMIT) && (v >= -dsc_pkg::DSC_OFS_LIMIT);
  endfunction : ofs_in_range

  function automatic logic sel_xyr(input logic [3:0] s);
    sel_xyr = (s >= {2'h0, dsc_pkg::DSC_SEL_X}) && (s <= {2'h0, dsc_pkg::DSC_SEL_R});
  endfunction : sel_xyr

  function automatic logic sel_aux(input logic [3:0] s);
    sel_aux = (s >= {1'b0, dsc_pkg::DSC_AUX_MIN}) && (s <= {1'b0, dsc_pkg::DSC_AUX_MAX});
  endfunction : sel_aux

  function automatic logic sel_slot(input logic [3:0] s);
    sel_slot = (s >= dsc_pkg::DSC_SLOT_MIN) && (s <= dsc_pkg::DSC_SLOT_MAX);
  endfunction : sel_slot

  // on/off style codes: only 0 and 1 are legal
  function automatic logic code_bit(input logic [2:0] c);
    code_bit = (c <= 3'h1);
  endfunction : code_bit

  wire logic [1:0] sel2 = cmd.sel[1:0];
  wire logic       is_set = cmd_valid && !cmd.query;
  // interface and override live outside the stored setup, so they get their own decode
  wire logic       take_iface = is_set && ok && (cmd.op == dsc_pkg::DSC_OP_INTERFACE);
  wire logic       take_ovr   = is_set && ok && (cmd.op == dsc_pkg::DSC_OP_LOCKOUT_OVR);
  // every command from GPIB counts for the remote state, accepted or not
  wire logic       from_gpib  = cmd_valid && cmd.from_gpib;

  // validity of the incoming command
  // ok gates every update below except the GPIB remote flag, so a refused command leaves all settings but remote_state alone
  always_comb
  begin
    ok = 1'b0;
    case (cmd.op)
      dsc_pkg::DSC_OP_DISPLAY_SELECT:
        ok = cmd.query || (cmd.has_sel && cmd.has_code
             && cmd.sel <= {1'b0, dsc_pkg::DSC_QTY_MAX}
             && cmd.code <= {1'b0, dsc_pkg::DSC_RATIO_MAX});
      dsc_pkg::DSC_OP_PANEL_OUTPUT:
        ok = cmd.query || (cmd.has_code && code_bit(cmd.code));
      dsc_pkg::DSC_OP_OFFSET_EXPAND:
        ok = cmd.has_sel && sel_xyr(cmd.sel)
             && (cmd.query || (cmd.has_val && cmd.has_code
             && ofs_in_range(cmd.val)
             && cmd.code <= {1'b0, dsc_pkg::DSC_EXPAND_MAX}));
      dsc_pkg::DSC_OP_AUTO_ZERO:
        ok = !cmd.query && cmd.has_sel && sel_xyr(cmd.sel);
      dsc_pkg::DSC_OP_AUX_INPUT:
        ok = cmd.query && cmd.has_sel && sel_aux(cmd.sel);
      dsc_pkg::DSC_OP_AUX_OUTPUT:
        ok = cmd.has_sel && sel_aux(cmd.sel) && (cmd.query || (cmd.has_val
             && cmd.val <= dsc_pkg::DSC_AUX_LIMIT
             && cmd.val >= -dsc_pkg::DSC_AUX_LIMIT));
      dsc_pkg::DSC_OP_INTERFACE,
      dsc_pkg::DSC_OP_KEY_CLICK,
      dsc_pkg::DSC_OP_ALARM:
        ok = cmd.query || (cmd.has_code && code_bit(cmd.code));
      dsc_pkg::DSC_OP_LOCKOUT_OVR:
        ok = !cmd.query && cmd.has_code && code_bit(cmd.code);
      dsc_pkg::DSC_OP_SAVE:
        ok = !cmd.query && cmd.has_sel && sel_slot(cmd.sel);
      // range test first: an index past the last slot never reaches the written flags
      dsc_pkg::DSC_OP_RECALL:
        ok = !cmd.query && cmd.has_sel && sel_slot(cmd.sel) && slot_used;
      default:
        ok = 1'b0;
    endcase
  end

  // next setup and reply
  always_comb
  begin
    setup_d = setup_q;
    // fields default to zero so no reply carries data left from an earlier command
    reply_d = '0;
    reply_d.to_gpib = gpib_q;
    if (cmd_valid && ok)
    begin
      case (cmd.op)
        dsc_pkg::DSC_OP_DISPLAY_SELECT:
          if (cmd.query)
          begin
            reply_d.two_fields = 1'b1;
            reply_d.first      = 16'(setup_q.qty);
            reply_d.second     = {1'b0, setup_q.ratio};
          end
          else
          begin
            setup_d.qty   = cmd.sel[2:0];
            setup_d.ratio = cmd.code[1:0];
          end
        dsc_pkg::DSC_OP_PANEL_OUTPUT:
          if (cmd.query)
            reply_d.first = 16'(setup_q.panel_src);
          else
            setup_d.panel_src = cmd.code[0];
        dsc_pkg::DSC_OP_OFFSET_EXPAND:
        begin
          reply_d.two_fields = 1'b1;
          if (sel2 == dsc_pkg::DSC_SEL_X)
          begin
            reply_d.first  = setup_q.ofs_x;
            reply_d.second = {1'b0, setup_q.exp_x};
          end
          else if (sel2 == dsc_pkg::DSC_SEL_Y)
          begin
            reply_d.first  = setup_q.ofs_y;
            reply_d.second = {1'b0, setup_q.exp_y};
          end
          else
          begin
            reply_d.first  = setup_q.ofs_r;
            reply_d.second = {1'b0, setup_q.exp_r};
          end
          if (!cmd.query)
          begin
            reply_d = '0;
            // a zero offset is simply stored as zero, which is the disabled state
            if (sel2 == dsc_pkg::DSC_SEL_X)
            begin
              setup_d.ofs_x = cmd.val;
              setup_d.exp_x = cmd.code[1:0];
            end
            else if (sel2 == dsc_pkg::DSC_SEL_Y)
            begin
              setup_d.ofs_y = cmd.val;
              setup_d.exp_y = cmd.code[1:0];
            end
            else
            begin
              setup_d.ofs_r = cmd.val;
              setup_d.exp_r = cmd.code[1:0];
            end
          end
        end
        dsc_pkg::DSC_OP_AUTO_ZERO:
          // offset equal to the present reading brings the output to zero; a reading beyond the limit is ignored
          if (sel2 == dsc_pkg::DSC_SEL_X)
            setup_d.ofs_x = ofs_in_range(meas_x) ? meas_x : setup_q.ofs_x;
          else if (sel2 == dsc_pkg::DSC_SEL_Y)
            setup_d.ofs_y = ofs_in_range(meas_y) ? meas_y : setup_q.ofs_y;
          else
            setup_d.ofs_r = ofs_in_range(meas_r) ? meas_r : setup_q.ofs_r;
        dsc_pkg::DSC_OP_AUX_INPUT:
          case (cmd.sel[2:0])
            3'h1:    reply_d.first = aux_in1;
            3'h2:    reply_d.first = aux_in2;
            3'h3:    reply_d.first = aux_in3;
            default: reply_d.first = aux_in4;
          endcase
        dsc_pkg::DSC_OP_AUX_OUTPUT:
          case (cmd.sel[2:0])
            3'h1:    if (cmd.query) reply_d.first = setup_q.aux_out1; else setup_d.aux_out1 = cmd.val;
            3'h2:    if (cmd.query) reply_d.first = setup_q.aux_out2; else setup_d.aux_out2 = cmd.val;
            3'h3:    if (cmd.query) reply_d.first = setup_q.aux_out3; else setup_d.aux_out3 = cmd.val;
            default: if (cmd.query) reply_d.first = setup_q.aux_out4; else setup_d.aux_out4 = cmd.val;
          endcase
        dsc_pkg::DSC_OP_INTERFACE:
          reply_d.first = 16'(gpib_q);
        dsc_pkg::DSC_OP_KEY_CLICK:
          if (cmd.query)
            reply_d.first = 16'(setup_q.key_click);
          else
            setup_d.key_click = cmd.code[0];
        dsc_pkg::DSC_OP_ALARM:
          if (cmd.query)
            reply_d.first = 16'(setup_q.alarm);
          else
            setup_d.alarm = cmd.code[0];
        dsc_pkg::DSC_OP_RECALL:
          setup_d = slot_data;
        default:
          setup_d = setup_q;
      endcase
    end
  end

  // a refused save must not mark its slot as written
  assign store_save = is_set && ok && (cmd.op == dsc_pkg::DSC_OP_SAVE);

  // save takes the registered setup, the state the host last had confirmed
  dsc_slot_store u_store (
    .clk     (clk),
    .reset_n (reset_n),
    .save    (store_save),
    .slot    (cmd.sel),
    .wdata   (setup_q),
    .rdata   (slot_data),
    .rvalid  (slot_used)
  );

  // pulses are registered so the formatter sees a clean one-cycle strobe per accepted query or refused command
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      setup_q       <= dsc_pkg::DSC_SETUP_RST;
      reply_q       <= '0;
      reply_valid_q <= 1'b0;
      error_q       <= 1'b0;
    end
    else
    begin
      setup_q       <= setup_d;
      reply_q       <= reply_d;
      reply_valid_q <= cmd_valid && ok && cmd.query;
      error_q       <= cmd_valid && !ok;
    end
  end

  // interface parameters live outside the stored setup, so recall never touches them
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gpib_q   <= 1'b0;
      ovr_q    <= 1'b0;
      remote_q <= 1'b0;
    end
    else
    begin
      if (take_iface)
        gpib_q <= cmd.code[0];
      if (take_ovr)
        ovr_q <= cmd.code[0];
      if (from_gpib)
        remote_q <= 1'b1;
    end
  end

  assign reply           = reply_q;
  assign reply_valid     = reply_valid_q;
  assign cmd_error       = error_q;
  assign setup           = setup_q;
  assign reply_gpib      = gpib_q;
  assign override_remote = ovr_q;
  assign remote_state    = remote_q;
  assign panel_locked    = remote_q && !ovr_q;

endmodule : dsc_cmd_exec
`default_nettype wire

// ==== shared/dsc_pkg.sv ====
// dsc_pkg: command codes, field encodings, limits and carrier structs for the display/output/setup command block
// assumes a front end has already parsed the text command into a decoded command struct
package dsc_pkg;

  typedef enum logic [3:0] {
    DSC_OP_DISPLAY_SELECT,
    DSC_OP_PANEL_OUTPUT,
    DSC_OP_OFFSET_EXPAND,
    DSC_OP_AUTO_ZERO,
    DSC_OP_AUX_INPUT,
    DSC_OP_AUX_OUTPUT,
    DSC_OP_INTERFACE,
    DSC_OP_LOCKOUT_OVR,
    DSC_OP_KEY_CLICK,
    DSC_OP_ALARM,
    DSC_OP_SAVE,
    DSC_OP_RECALL
  } dsc_op_t;

  localparam logic [2:0] DSC_QTY_MAX      = 3'h4;
  localparam logic [1:0] DSC_RATIO_MAX    = 2'h2;
  localparam logic [1:0] DSC_EXPAND_MAX   = 2'h2;
  localparam logic [1:0] DSC_SEL_X        = 2'h1;
  localparam logic [1:0] DSC_SEL_Y        = 2'h2;
  localparam logic [1:0] DSC_SEL_R        = 2'h3;
  localparam logic [2:0] DSC_AUX_MIN      = 3'h1;
  localparam logic [2:0] DSC_AUX_MAX      = 3'h4;
  localparam logic [3:0] DSC_SLOT_MIN     = 4'h1;
  localparam logic [3:0] DSC_SLOT_MAX     = 4'h9;
  localparam int         DSC_SLOTS        = 10;
  // offset in hundredths of a percent, +-105.00
  localparam logic signed [15:0] DSC_OFS_LIMIT = 16'sh2904;
  // aux output in millivolts, +-10.500 V
  localparam logic signed [15:0] DSC_AUX_LIMIT = 16'sh2904;
  localparam logic [15:0] DSC_ZERO16       = 16'h0000;

  typedef struct packed {
    dsc_op_t            op;
    logic               query;
    logic               has_sel;
    logic [3:0]         sel;
    logic               has_val;
    logic signed [15:0] val;
    logic               has_code;
    logic [2:0]         code;
    logic               from_gpib;
  } dsc_cmd_t;

  // answer fields; text formatting ("a,b") is done by the reply formatter outside
  typedef struct packed {
    logic               two_fields;
    logic signed [15:0] first;
    logic [2:0]         second;
    logic               to_gpib;
  } dsc_reply_t;

  typedef struct packed {
    logic [2:0]         qty;
    logic [1:0]         ratio;
    logic               panel_src;
    logic signed [15:0] ofs_x;
    logic signed [15:0] ofs_y;
    logic signed [15:0] ofs_r;
    logic [1:0]         exp_x;
    logic [1:0]         exp_y;
    logic [1:0]         exp_r;
    logic signed [15:0] aux_out1;
    logic signed [15:0] aux_out2;
    logic signed [15:0] aux_out3;
    logic signed [15:0] aux_out4;
    logic               key_click;
    logic               alarm;
  } dsc_setup_t;

  localparam dsc_setup_t DSC_SETUP_RST = '0;

endpackage : dsc_pkg

// ==== src/dsc_slot_store.sv ====
// dsc_slot_store: ten setup slots with a written flag each; the executor uses slots 1 to 9
// assumes the array is mapped to nonvolatile storage by the implementation flow
`timescale 1ns/1ps
`default_nettype none
module dsc_slot_store (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             save,
  input  wire logic [3:0]       slot,
  input  wire dsc_pkg::dsc_setup_t wdata,
  output dsc_pkg::dsc_setup_t   rdata,
  output logic                  rvalid
);
  dsc_pkg::dsc_setup_t mem [dsc_pkg::DSC_SLOTS];
  logic [dsc_pkg::DSC_SLOTS-1:0] used_q;

  // contents are not reset: they stand for retained storage
  always_ff @(posedge clk)
  begin
    if (save)
      mem[slot] <= wdata;
  end

  // the written flags belong with the retained storage; cleared only by cold reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      used_q <= '0;
    else if (save)
      used_q[slot] <= 1'b1;
  end

  assign rdata  = mem[slot];
  assign rvalid = used_q[slot];
endmodule : dsc_slot_store
`default_nettype wire

// ==== sim/dsc_host_model.sv ====
// dsc_host_model: host side issuing decoded commands to the executor
// assumes the bench calls send then idle; drives on the falling edge
`timescale 1ns/1ps
`default_nettype none
module dsc_host_model (
  input  wire logic         clk,
  output dsc_pkg::dsc_cmd_t cmd,
  output logic              cmd_valid
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end
  // the bench supplies selector, value and code fields, each marked present or absent by has_sel, has_val or has_code
  task automatic send(input dsc_pkg::dsc_cmd_t c);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd       = c;
  endtask : send
  // released fields show the inverse so stale values are never reused
  task automatic idle();
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd       = dsc_pkg::dsc_cmd_t'(~cmd);
  endtask : idle
endmodule : dsc_host_model
`default_nettype wire

// ==== sim/dsc_asserts.sv ====
// dsc_asserts: timing and range checks on the command executor ports
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module dsc_asserts (
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                cmd_valid,
  input wire dsc_pkg::dsc_cmd_t   cmd,
  input wire logic                reply_valid,
  input wire dsc_pkg::dsc_reply_t reply,
  input wire logic                cmd_error,
  input wire dsc_pkg::dsc_setup_t setup,
  input wire logic                reply_gpib,
  input wire logic                override_remote,
  input wire logic                remote_state,
  input wire logic                panel_locked
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  function automatic logic in_lim(logic signed [15:0] x);
    return x <= 16'sh2904 && x >= -16'sh2904;
  endfunction : in_lim
  a_reply_needs_query: assert property (reply_valid |-> $past(cmd_valid) && $past(cmd.query))
    else $error("reply without a query");
  a_error_needs_cmd: assert property (cmd_error |-> $past(cmd_valid) && !reply_valid)
    else $error("error without a command");
  a_error_keeps_setup: assert property (cmd_error |-> $stable(setup))
    else $error("setup changed on a rejected command");
  a_gpib_goes_remote: assert property (cmd_valid && cmd.from_gpib |=> remote_state [*2])
    else $error("gpib command did not hold remote");
  a_lock_follows: assert property (panel_locked == (remote_state && !override_remote))
    else $error("panel lock mismatch");
  a_reply_route: assert property (reply_valid |-> reply.to_gpib == reply_gpib)
    else $error("reply routed to wrong interface");
  a_offset_limit: assert property (in_lim(setup.ofs_x) && in_lim(setup.ofs_y) && in_lim(setup.ofs_r))
    else $error("offset beyond limit");
  a_aux_limit: assert property (in_lim(setup.aux_out1) && in_lim(setup.aux_out2) && in_lim(setup.aux_out3) &&
    in_lim(setup.aux_out4))
    else $error("aux output beyond limit");
  a_expand_codes: assert property (setup.exp_x != 2'h3 && setup.exp_y != 2'h3 && setup.exp_r != 2'h3)
    else $error("illegal expand code");
  a_display_takes: assert property (cmd_valid && !cmd.query && cmd.op == dsc_pkg::DSC_OP_DISPLAY_SELECT &&
    cmd.has_sel && cmd.has_code && cmd.sel <= 4'h4 && cmd.code <= 3'h2 |=> setup.qty == $past(cmd.sel[2:0]))
    else $error("display quantity not taken");
  a_click_takes: assert property (cmd_valid && !cmd.query && cmd.op == dsc_pkg::DSC_OP_KEY_CLICK &&
    cmd.has_code && cmd.code <= 3'h1 |=> setup.key_click == $past(cmd.code[0]))
    else $error("key click not taken");
endmodule : dsc_asserts
bind dsc_cmd_exec dsc_asserts dsc_asserts_i (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
  .reply_valid(reply_valid), .reply(reply), .cmd_error(cmd_error), .setup(setup), .reply_gpib(reply_gpib),
  .override_remote(override_remote), .remote_state(remote_state), .panel_locked(panel_locked));
`default_nettype wire

// ==== sim/tb.sv ====
// tb: self-checking bench for dsc_cmd_exec driven through a host model
// assumes one 40 MHz clock; expected state lives in a shadow setup
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [1:0]          k;
    dsc_pkg::dsc_reply_t r;
  } dsc_exp_t;
  localparam int NV = 32'h1869f;
  logic                clk, reset_n, cmd_valid, reply_valid, cmd_error, reply_gpib, ovr, rem, lock;
  logic signed [15:0]  mx, my, mr, a1, a2, a3, a4, v;
  logic signed [15:0]  ov [6];
  dsc_pkg::dsc_cmd_t   cmd;
  dsc_pkg::dsc_reply_t reply;
  dsc_pkg::dsc_setup_t setup, es, s9;
  dsc_exp_t            e, em;
  dsc_exp_t            expq[$];
  logic                gp, eo, er, fg, ok;
  int                  n_fail, checks, i, j;

  dsc_host_model dsc_host_model_i (.clk(clk), .cmd(cmd), .cmd_valid(cmd_valid));
  dsc_cmd_exec dsc_cmd_exec_i (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd), .meas_x(mx),
    .meas_y(my), .meas_r(mr), .aux_in1(a1), .aux_in2(a2), .aux_in3(a3), .aux_in4(a4), .reply_valid(reply_valid),
    .reply(reply), .cmd_error(cmd_error), .setup(setup), .reply_gpib(reply_gpib), .override_remote(ovr),
    .remote_state(rem), .panel_locked(lock));

  function automatic dsc_pkg::dsc_cmd_t mk(dsc_pkg::dsc_op_t op, logic q, int s, int x, int c);
    mk           = '0;
    mk.op        = op;
    mk.query     = q;
    mk.has_sel   = s >= 0;
    mk.sel       = s[3:0];
    mk.has_val   = x != NV;
    mk.val       = x[15:0];
    mk.has_code  = c >= 0;
    mk.code      = c[2:0];
    mk.from_gpib = fg;
  endfunction : mk
  task automatic check(string n, logic [127:0] x, logic [127:0] g);
    checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask : check
  // every command ends at a falling edge, so the shadow state is compared settled
  task automatic go(dsc_pkg::dsc_cmd_t c, int k, logic signed [15:0] f = 0, int s = 0, logic t = 0);
    e.k = k[1:0];
    e.r = '{t, f, s[2:0], gp};
    if (k != 0)
      expq.push_back(e);
    dsc_host_model_i.send(c);
    dsc_host_model_i.idle();
    er = er | c.from_gpib;
    check("pending", 0, expq.size());
    check("setup", es, setup);
    check("flags", {gp, eo, er, er & ~eo}, {reply_gpib, ovr, rem, lock});
  endtask : go
  task automatic put(int q, logic signed [15:0] x, int c);
    if (q == 1) es.ofs_x = x;
    if (q == 2) es.ofs_y = x;
    if (q == 3) es.ofs_r = x;
    if (q == 1 && c >= 0) es.exp_x = c[1:0];
    if (q == 2 && c >= 0) es.exp_y = c[1:0];
    if (q == 3 && c >= 0) es.exp_r = c[1:0];
  endtask : put
  task automatic do_reset();
    @(negedge clk);
    reset_n = 1'b0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    {es, gp, eo, er} = '0;
  endtask : do_reset
  task automatic report_and_stop();
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // results are sampled just after the edge that registers them
  always @(posedge clk)
  begin
    #1;
    if (reset_n === 1'b1 && (reply_valid === 1'b1 || cmd_error === 1'b1))
    begin
      em = expq.size() ? expq.pop_front() : '0;
      check("error", em.k == 2'h1, cmd_error);
      check("result", 1'b1, em.k != 2'h0);
      if (em.k == 2'h3)
        check("reply", em.r, reply);
    end
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    {reset_n, mx, my, mr, a1, a2, a3, a4, n_fail, checks, fg} = '0;
    ov = '{16'sh2904, -16'sh2904, 16'sh0, 16'sh0, 16'sh2905, -16'sh2905};
    void'($urandom(32'h95b2));
    do_reset();
    gp = 1'b1;
    go(mk(dsc_pkg::DSC_OP_INTERFACE, 0, -1, NV, 1), 0);
    go(mk(dsc_pkg::DSC_OP_INTERFACE, 1, -1, NV, -1), 3, 1);
    fg = 1'b1;
    for (i = 0; i <= 5; i++)
      for (j = 0; j <= 3; j++)
      begin
        ok = i <= 4 && j <= 2;
        if (ok)
          {es.qty, es.ratio} = {i[2:0], j[1:0]};
        go(mk(dsc_pkg::DSC_OP_DISPLAY_SELECT, 0, i, NV, j), ok ? 0 : 1);
        go(mk(dsc_pkg::DSC_OP_DISPLAY_SELECT, 1, -1, NV, -1), 3, 16'(es.qty), es.ratio, 1);
      end
    for (j = 2; j >= 0; j--)
    begin
      if (j < 2)
        es.panel_src = j[0];
      go(mk(dsc_pkg::DSC_OP_PANEL_OUTPUT, 0, -1, NV, j), j == 2);
      go(mk(dsc_pkg::DSC_OP_PANEL_OUTPUT, 1, -1, NV, -1), 3, es.panel_src);
    end
    for (i = 0; i <= 4; i++)
      for (j = 0; j <= 5; j++)
      begin
        ov[3] = $signed(16'($urandom_range(32'h5208))) - 16'sh2904;
        ok = i >= 1 && i <= 3 && j <= 3;
        if (ok)
          put(i, ov[j], j % 3);
        go(mk(dsc_pkg::DSC_OP_OFFSET_EXPAND, 0, i, ov[j], j % 3), !ok);
        if (ok)
          go(mk(dsc_pkg::DSC_OP_OFFSET_EXPAND, 1, i, NV, -1), 3, ov[j], j % 3, 1);
      end
    go(mk(dsc_pkg::DSC_OP_OFFSET_EXPAND, 0, 1, 5, 3), 1);
    go(mk(dsc_pkg::DSC_OP_OFFSET_EXPAND, 0, 1, 5, -1), 1);
    go(mk(dsc_pkg::DSC_OP_OFFSET_EXPAND, 1, -1, NV, -1), 1);
    for (i = 0; i <= 4; i++)
    begin
      mx = $signed(16'($urandom_range(32'h5208))) - 16'sh2904;
      my = $signed(16'($urandom_range(32'h5208))) - 16'sh2904;
      mr = $signed(16'($urandom_range(32'h5208))) - 16'sh2904;
      if (i >= 1 && i <= 3)
        put(i, (i == 1) ? mx : (i == 2) ? my : mr, -1);
      go(mk(dsc_pkg::DSC_OP_AUTO_ZERO, 0, i, NV, -1), i == 0 || i == 4);
    end
    go(mk(dsc_pkg::DSC_OP_AUTO_ZERO, 1, 1, NV, -1), 1);
    mx = 16'sh2905;
    go(mk(dsc_pkg::DSC_OP_AUTO_ZERO, 0, 1, NV, -1), 0);
    for (i = 0; i <= 5; i++)
    begin
      {a1, a2, a3, a4} = {$urandom, $urandom};
      v = (i == 1) ? a1 : (i == 2) ? a2 : (i == 3) ? a3 : a4;
      go(mk(dsc_pkg::DSC_OP_AUX_INPUT, 1, i, NV, -1), (i >= 1 && i <= 4) ? 3 : 1, v);
    end
    go(mk(dsc_pkg::DSC_OP_AUX_INPUT, 0, 1, NV, -1), 1);
    for (i = 0; i <= 5; i++)
      for (j = 0; j <= 5; j++)
      begin
        ok = i >= 1 && i <= 4 && j <= 3;
        if (ok)
          {es.aux_out1, es.aux_out2, es.aux_out3, es.aux_out4} = {i == 1 ? ov[j] : es.aux_out1,
            i == 2 ? ov[j] : es.aux_out2, i == 3 ? ov[j] : es.aux_out3, i == 4 ? ov[j] : es.aux_out4};
        go(mk(dsc_pkg::DSC_OP_AUX_OUTPUT, 0, i, ov[j], -1), !ok);
        if (ok)
          go(mk(dsc_pkg::DSC_OP_AUX_OUTPUT, 1, i, NV, -1), 3, ov[j]);
      end
    for (j = 2; j >= 0; j--)
    begin
      if (j < 2)
        eo = j[0];
      go(mk(dsc_pkg::DSC_OP_LOCKOUT_OVR, 0, -1, NV, j), j == 2);
      if (j < 2)
        es.key_click = j[0];
      go(mk(dsc_pkg::DSC_OP_KEY_CLICK, 0, -1, NV, j), j == 2);
      if (j < 2)
        es.alarm = j[0];
      go(mk(dsc_pkg::DSC_OP_ALARM, 0, -1, NV, j), j == 2);
      go(mk(dsc_pkg::DSC_OP_ALARM, 1, -1, NV, -1), 3, es.alarm);
      go(mk(dsc_pkg::DSC_OP_KEY_CLICK, 1, -1, NV, -1), 3, es.key_click);
    end
    go(mk(dsc_pkg::DSC_OP_LOCKOUT_OVR, 1, -1, NV, -1), 1);
    go(mk(dsc_pkg::DSC_OP_SAVE, 0, 9, NV, -1), 0);
    s9 = es;
    es.key_click = 1'b1;
    go(mk(dsc_pkg::DSC_OP_KEY_CLICK, 0, -1, NV, 1), 0);
    gp = 1'b0;
    go(mk(dsc_pkg::DSC_OP_INTERFACE, 0, -1, NV, 0), 0);
    es = s9;
    go(mk(dsc_pkg::DSC_OP_RECALL, 0, 9, NV, -1), 0);
    go(mk(dsc_pkg::DSC_OP_RECALL, 0, 1, NV, -1), 1);
    go(mk(dsc_pkg::DSC_OP_SAVE, 0, 10, NV, -1), 1);
    go(mk(dsc_pkg::DSC_OP_RECALL, 0, 0, NV, -1), 1);
    do_reset();
    fg = 1'b0;
    go(mk(dsc_pkg::DSC_OP_RECALL, 0, 9, NV, -1), 1);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
